// ### include/slsm_pkg.sv
// Constants and types for the lane sample mapper
`default_nettype none

package slsm_pkg;

    // ==========================================================
    // Lane-format mode codes
    localparam logic [5:0] MODE_S12_6L = 6'h20;
    localparam logic [5:0] MODE_D12_6L = 6'h21;
    localparam logic [5:0] MODE_S8_4L = 6'h22;
    localparam logic [5:0] MODE_D8_4L = 6'h23;
    localparam logic [5:0] MODE_D15_4L = 6'h25;
    localparam logic [5:0] MODE_S15_2L = 6'h26;
    localparam logic [5:0] MODE_D15_2L = 6'h27;
    localparam logic [5:0] MODE_D15_2L16 = 6'h38;

    // ==========================================================
    // Powered lanes per mode, bit order {b2,b1,b0,a2,a1,a0}
    localparam logic [5:0] EN_6L = 6'h3f;
    localparam logic [5:0] EN_4L = 6'h1b;
    localparam logic [5:0] EN_2L = 6'h09;
    localparam logic [5:0] EN_NONE = 6'h00;

    // Octets per lane per frame
    localparam logic [2:0] OCT_1 = 3'h1;
    localparam logic [2:0] OCT_2 = 3'h2;
    localparam logic [2:0] OCT_4 = 3'h4;
    localparam logic [2:0] OCT_0 = 3'h0;

    // ==========================================================
    // Lane indices and sizes
    localparam int LN_A0 = 0;
    localparam int LN_A1 = 1;
    localparam int LN_A2 = 2;
    localparam int LN_B0 = 3;
    localparam int LN_B1 = 4;
    localparam int LN_B2 = 5;
    localparam int LANE_N = 6;
    localparam int LANE_W = 32;
    localparam int SLOT_N = 8;
    localparam int SLOT_W = 16;
    localparam int FIFO_DEPTH = 16;

    // ==========================================================
    // Sync-header and test-select codes
    localparam logic [1:0] SH_FEC = 2'h1;
    localparam logic [3:0] TEST_OFF = 4'h0;

    // ==========================================================
    // Six over-range flags above eight sample slots
    typedef struct packed {
        logic ovr_b_second;
        logic ovr_b_first;
        logic ovr_a_second;
        logic ovr_a_first;
        logic ovr_second;
        logic ovr_first;
        logic [SLOT_N-1:0][SLOT_W-1:0] slot;
    } slsm_word_type;

    localparam int WORD_W = $bits(slsm_word_type);

    // One channel's view in dual modes
    typedef struct packed {
        logic [3:0][SLOT_W-1:0] s;
        logic f1;
        logic f0;
    } slsm_chan_type;

    // Lane halves of one 12-bit group
    typedef logic [2:0][15:0] slsm_grp_type;

endpackage

`default_nettype wire

// ### include/slsm_stream_if.sv
// Valid/ready carrier between the mapper's modules
`timescale 1ns/1ps
`default_nettype none

interface slsm_stream_if #(
    parameter int W = 8
);
    logic [W-1:0] data;
    logic valid;
    logic ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

// ### logic/slsm_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module slsm_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } slsm_sync_type;

    slsm_sync_type st;
    slsm_sync_type next_st;

    // ==========================================================
    // Level only moves once the last two stages agree
    always_comb begin
        next_st = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.q = st.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign dout = st.q;
endmodule // slsm_sync

`default_nettype wire

// ### logic/slsm_fifo.sv
// Sample FIFO with registered read data and flush
`timescale 1ns/1ps
`default_nettype none

module slsm_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic flush,
    slsm_stream_if.snk wr,
    slsm_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
        logic [W-1:0] out;
        logic ov;
    } slsm_fifo_type;

    slsm_fifo_type st;
    slsm_fifo_type next_st;
    logic push;
    logic take;

    // ==========================================================
    // Output register refills when empty or drained
    always_comb begin
        next_st = st;
        push = wr.valid && !st.full;
        take = (!st.ov || rd.ready) && (st.cnt != '0);
        if (push) begin
            next_st.mem[st.wp] = wr.data;
            next_st.wp = st.wp + AW'(1);
        end
        if (take) begin
            next_st.out = st.mem[st.rp];
            next_st.rp = st.rp + AW'(1);
            next_st.ov = 1'b1;
        end else if (rd.ready) begin
            next_st.ov = 1'b0;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(take);
        next_st.full = (next_st.cnt == (AW+1)'(DEPTH));
        // Flush drops all words, stale ones must not leak out
        if (flush) begin
            next_st.wp = '0;
            next_st.rp = '0;
            next_st.cnt = '0;
            next_st.full = 1'b0;
            next_st.ov = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Ready from a flop: a clean level for the source
    assign wr.ready = !st.full;
    assign rd.valid = st.ov;
    assign rd.data = st.out;
endmodule // slsm_fifo

`default_nettype wire

// ### logic/slsm_top.sv
// Lane sample mapper: packs samples into lane octets by mode
//
// Contract
// - Mode 32: even samples A, odd B, 12-bit packed
// - Mode 33: four A samples A lanes, B likewise
// - Mode 34: A0 s0, A1 s2, B0 s1, B1 s3
// - Mode 35: A lanes channel A, B lanes B
// - Mode 37: I and Q on separate lanes, one word each with flag
// - Mode 38: I on A0, Q on B0, flags
// - Mode 39: four octets, I then Q, per channel
// - Mode 56 uses the mode 39 layout
// - Only the 12-bit check, no 3-bit variant
// - Sync-header mode selects error correction
// - Binding routes one converter to both channels
// - Redundant data on both links, dual modes only
// - Power-down disables serial output drivers
// - One channel may power down, other runs
// - Test select; powered lanes still follow mode
`timescale 1ns/1ps
`default_nettype none

module slsm_top
    import slsm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [5:0] lane_format_select,
    input wire logic [1:0] sync_header_mode,
    input wire logic route_bind_a,
    input wire logic route_bind_b,
    input wire logic chan_a_powerdown,
    input wire logic chan_b_powerdown,
    input wire logic full_powerdown_pin,
    input wire logic cfg_mode_powerdown,
    input wire logic [3:0] serializer_test_select,
    input wire logic in_valid,
    input wire logic [SLOT_N-1:0][SLOT_W-1:0] in_samples,
    input wire logic overrange_first,
    input wire logic overrange_second,
    input wire logic overrange_chan_a_first,
    input wire logic overrange_chan_a_second,
    input wire logic overrange_chan_b_first,
    input wire logic overrange_chan_b_second,
    input wire logic lane_ready,
    output logic in_ready,
    output logic [LANE_W-1:0] lane_a0,
    output logic [LANE_W-1:0] lane_a1,
    output logic [LANE_W-1:0] lane_a2,
    output logic [LANE_W-1:0] lane_b0,
    output logic [LANE_W-1:0] lane_b1,
    output logic [LANE_W-1:0] lane_b2,
    output logic [LANE_N-1:0] lane_enable,
    output logic [2:0] lane_octets,
    output logic frame_valid,
    output logic fec_select,
    output logic test_active
);

    // ==========================================================
    // State and helpers

    typedef struct packed {
        logic [LANE_N-1:0][LANE_W-1:0] lane;
        logic [LANE_N-1:0] lane_en;
        logic [2:0] octets;
        logic fvalid;
        logic fec;
        logic test;
    } slsm_top_type;

    slsm_top_type st;
    slsm_top_type next_st;

    // Four 12-bit samples over three lane halves,
    // first sample leading
    function automatic slsm_grp_type pack12(
        input logic [15:0] a,
        input logic [15:0] b,
        input logic [15:0] c,
        input logic [15:0] d
    );
        logic [47:0] g;
        g = {a[11:0], b[11:0], c[11:0], d[11:0]};
        return {g[15:0], g[31:16], g[47:32]};
    endfunction

    // 16-bit word in octets 0 and 1
    function automatic logic [LANE_W-1:0] lane16(
        input logic [15:0] v
    );
        return {v, 16'h0000};
    endfunction

    // 8-bit word in octet 0
    function automatic logic [LANE_W-1:0] lane8(
        input logic [15:0] v
    );
        return {v[7:0], 24'h000000};
    endfunction

    // 15-bit word, over-range flag last
    function automatic logic [15:0] word15(
        input logic [15:0] v,
        input logic f
    );
        return {v[14:0], f};
    endfunction

    // ==========================================================
    // Power-down pin synchroniser

    logic pd_pin_sync;

    slsm_sync u_pd_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .din(full_powerdown_pin),
        .dout(pd_pin_sync)
    );

    // ==========================================================
    // Sample FIFO in the data path

    slsm_stream_if #(.W(WORD_W)) fifo_in ();
    slsm_stream_if #(.W(WORD_W)) fifo_out ();

    slsm_word_type in_word;
    logic powered_down;
    logic test_on;

    // Input ports into one FIFO word
    always_comb begin
        in_word.slot = in_samples;
        in_word.ovr_first = overrange_first;
        in_word.ovr_second = overrange_second;
        in_word.ovr_a_first = overrange_chan_a_first;
        in_word.ovr_a_second = overrange_chan_a_second;
        in_word.ovr_b_first = overrange_chan_b_first;
        in_word.ovr_b_second = overrange_chan_b_second;
    end

    assign fifo_in.data = in_word;
    assign fifo_in.valid = in_valid;

    // Drain when down or testing: nothing stale survives
    assign fifo_out.ready = !st.fvalid || lane_ready || powered_down || test_on;

    slsm_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .flush(powered_down || test_on),
        .wr(fifo_in.snk),
        .rd(fifo_out.src)
    );

    // ==========================================================
    // Mode decode and channel routing

    slsm_word_type w;
    slsm_chan_type ca;
    slsm_chan_type cb;
    slsm_chan_type sa;
    slsm_chan_type sb;
    logic dual;
    logic a_from_b;
    logic b_from_a;

    // Pin or config field powers down
    assign powered_down = pd_pin_sync || cfg_mode_powerdown;
    assign test_on = serializer_test_select != TEST_OFF;

    // Channel views, binding, then channel power-down
    always_comb begin
        w = fifo_out.data;
        dual = (lane_format_select == MODE_D12_6L)
            || (lane_format_select == MODE_D8_4L)
            || (lane_format_select == MODE_D15_4L)
            || (lane_format_select == MODE_D15_2L)
            || (lane_format_select == MODE_D15_2L16);
        if (lane_format_select == MODE_D12_6L) begin
            ca.s = w.slot[3:0];
            cb.s = w.slot[7:4];
        end else begin
            ca.s = {32'h00000000, w.slot[1:0]};
            cb.s = {32'h00000000, w.slot[3:2]};
        end
        ca.f0 = w.ovr_a_first;
        ca.f1 = w.ovr_a_second;
        cb.f0 = w.ovr_b_first;
        cb.f1 = w.ovr_b_second;
        // Single-channel modes ignore binding
        a_from_b = dual && route_bind_b;
        b_from_a = dual && route_bind_a;
        sa = a_from_b ? cb : ca;
        sb = b_from_a ? ca : cb;
        // In dual modes a converter that is off feeds zeros
        if (dual && (a_from_b ? chan_b_powerdown : chan_a_powerdown)) begin
            sa = '0;
        end
        if (dual && (b_from_a ? chan_a_powerdown : chan_b_powerdown)) begin
            sb = '0;
        end
    end

    // ==========================================================
    // Lane mapping per mode

    logic [LANE_N-1:0][LANE_W-1:0] ln;
    logic [LANE_N-1:0] en;
    logic [2:0] oct;
    logic known;
    slsm_grp_type ga;
    slsm_grp_type gb;

    always_comb begin
        ln = '0;
        en = EN_NONE;
        oct = OCT_0;
        known = 1'b1;
        ga = '0;
        gb = '0;
        case (lane_format_select)
            MODE_S12_6L: begin
                ga = pack12(w.slot[0], w.slot[2], w.slot[4], w.slot[6]);
                gb = pack12(w.slot[1], w.slot[3], w.slot[5], w.slot[7]);
                en = EN_6L;
                oct = OCT_2;
            end
            MODE_D12_6L: begin
                ga = pack12(sa.s[0], sa.s[1], sa.s[2], sa.s[3]);
                gb = pack12(sb.s[0], sb.s[1], sb.s[2], sb.s[3]);
                en = EN_6L;
                oct = OCT_2;
            end
            MODE_S8_4L: begin
                ln[LN_A0] = lane8(w.slot[0]);
                ln[LN_A1] = lane8(w.slot[2]);
                ln[LN_B0] = lane8(w.slot[1]);
                ln[LN_B1] = lane8(w.slot[3]);
                en = EN_4L;
                oct = OCT_1;
            end
            MODE_D8_4L: begin
                ln[LN_A0] = lane8(sa.s[0]);
                ln[LN_A1] = lane8(sa.s[1]);
                ln[LN_B0] = lane8(sb.s[0]);
                ln[LN_B1] = lane8(sb.s[1]);
                en = EN_4L;
                oct = OCT_1;
            end
            MODE_D15_4L: begin
                ln[LN_A0] = lane16(word15(sa.s[0], sa.f0));
                ln[LN_A1] = lane16(word15(sa.s[1], sa.f1));
                ln[LN_B0] = lane16(word15(sb.s[0], sb.f0));
                ln[LN_B1] = lane16(word15(sb.s[1], sb.f1));
                en = EN_4L;
                oct = OCT_2;
            end
            MODE_S15_2L: begin
                ln[LN_A0] = lane16(word15(w.slot[0], w.ovr_first));
                ln[LN_B0] = lane16(word15(w.slot[1], w.ovr_second));
                en = EN_2L;
                oct = OCT_2;
            end
            MODE_D15_2L, MODE_D15_2L16: begin
                // Both rates share one layout
                ln[LN_A0] = {word15(sa.s[0], sa.f0), word15(sa.s[1], sa.f1)};
                ln[LN_B0] = {word15(sb.s[0], sb.f0), word15(sb.s[1], sb.f1)};
                en = EN_2L;
                oct = OCT_4;
            end
            default: begin
                // Unlisted codes stay idle, never half-mapped
                known = 1'b0;
            end
        endcase
        // 12-bit groups fill octets 0 and 1
        if (lane_format_select == MODE_S12_6L || lane_format_select == MODE_D12_6L) begin
            ln[LN_A0] = lane16(ga[0]);
            ln[LN_A1] = lane16(ga[1]);
            ln[LN_A2] = lane16(ga[2]);
            ln[LN_B0] = lane16(gb[0]);
            ln[LN_B1] = lane16(gb[1]);
            ln[LN_B2] = lane16(gb[2]);
        end
    end

    // ==========================================================
    // Output stage

    // Frame held until the link takes it
    always_comb begin
        next_st = st;
        // Correction or the 12-bit check, never a 3-bit one
        next_st.fec = (sync_header_mode == SH_FEC);
        next_st.test = test_on;
        // Lanes follow mode under test, off when down
        next_st.lane_en = powered_down ? EN_NONE : en;
        next_st.octets = oct;
        if (powered_down || test_on) begin
            // Data withheld while the FIFO flushes
            next_st.fvalid = 1'b0;
            next_st.lane = '0;
        end else if (!st.fvalid || lane_ready) begin
            if (fifo_out.valid && known) begin
                next_st.lane = ln;
                next_st.fvalid = 1'b1;
            end else begin
                next_st.fvalid = 1'b0;
                next_st.lane = known ? st.lane : '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Port drive, all from flops

    assign in_ready = fifo_in.ready;
    assign lane_a0 = st.lane[LN_A0];
    assign lane_a1 = st.lane[LN_A1];
    assign lane_a2 = st.lane[LN_A2];
    assign lane_b0 = st.lane[LN_B0];
    assign lane_b1 = st.lane[LN_B1];
    assign lane_b2 = st.lane[LN_B2];
    assign lane_enable = st.lane_en;
    assign lane_octets = st.octets;
    assign frame_valid = st.fvalid;
    assign fec_select = st.fec;
    assign test_active = st.test;

endmodule // slsm_top

`default_nettype wire

// ### test/slsm_props.sv
// Port-level checker for the lane sample mapper
`timescale 1ns/1ps
`default_nettype none

module slsm_props
    import slsm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic lane_ready,
    input wire logic [1:0] sync_header_mode,
    input wire logic cfg_mode_powerdown,
    input wire logic full_powerdown_pin,
    input wire logic [3:0] serializer_test_select,
    input wire logic frame_valid,
    input wire logic [LANE_W-1:0] lane_a0,
    input wire logic [LANE_W-1:0] lane_b0,
    input wire logic [LANE_N-1:0] lane_enable,
    input wire logic [2:0] lane_octets,
    input wire logic fec_select,
    input wire logic test_active
);
    // ==========================================================
    // Reset, power-down and test gating, sync-header select
    AST_RESET_IDLE:
    assert property (@(posedge clk) reset |=> !frame_valid && lane_enable == EN_NONE)
        else $error("lanes active after reset");
    AST_CFG_PD:
    assert property (@(posedge clk) disable iff (reset) cfg_mode_powerdown && ce
        |=> lane_enable == EN_NONE && !frame_valid) else $error("config power-down ignored");
    // Six samples cover the pin synchroniser
    AST_PIN_PD:
    assert property (@(posedge clk) disable iff (reset) full_powerdown_pin [*6]
        |-> lane_enable == EN_NONE && !frame_valid && lane_a0 == '0)
        else $error("pin power-down ignored");
    AST_TEST_ON:
    assert property (@(posedge clk) disable iff (reset) serializer_test_select != TEST_OFF && ce
        |=> test_active && !frame_valid) else $error("test not gating");
    AST_FEC:
    assert property (@(posedge clk) disable iff (reset) ce
        |=> fec_select == ($past(sync_header_mode) == SH_FEC)) else $error("sync-header select");
    // ==========================================================
    // Frame shape
    AST_FRAME_HOLD:
    assert property (@(posedge clk) disable iff (reset) frame_valid && !lane_ready && ce
        && !cfg_mode_powerdown && !full_powerdown_pin && serializer_test_select == TEST_OFF
        |=> frame_valid && $stable(lane_a0) && $stable(lane_b0)) else $error("frame not held");
    AST_OCT_LANES:
    assert property (@(posedge clk) disable iff (reset) frame_valid
        |-> (lane_octets == OCT_4 && lane_enable == EN_2L)
        || (lane_octets == OCT_1 && lane_enable == EN_4L)
        || (lane_octets == OCT_2 && lane_enable != EN_NONE)) else $error("lane count vs octets");
    AST_UNKNOWN_IDLE:
    assert property (@(posedge clk) disable iff (reset) lane_octets == OCT_0
        |-> !frame_valid && lane_enable == EN_NONE) else $error("unknown mode not idle");
    AST_UNUSED_ZERO:
    assert property (@(posedge clk) disable iff (reset) frame_valid && lane_octets == OCT_1
        |-> lane_a0[23:0] == 24'h0 && lane_b0[23:0] == 24'h0) else $error("unused octets set");
endmodule // slsm_props

`default_nettype wire

// ### test/slsm_rx_model.sv
// Receiver model: takes frames, logs lane A0 octet 0
`timescale 1ns/1ps
`default_nettype none

module slsm_rx_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic frame_valid,
    input wire logic [191:0] lanes,
    output logic lane_ready,
    output logic [191:0] got
);
    logic [7:0] seen[$];
    // Back-pressure at will
    assign lane_ready = !stall;
    // Taken only at an edge with ready high
    always @(posedge clk) begin
        if (frame_valid === 1'b1 && lane_ready) begin
            got <= lanes;
            seen.push_back(lanes[31:24]);
        end
    end
endmodule // slsm_rx_model

`default_nettype wire

// ### test/slsm_top_bench.sv
// Self-checking bench for the lane sample mapper
`timescale 1ns/1ps
`default_nettype none

module slsm_top_bench
    import slsm_pkg::*;
;
    logic clk, reset, in_valid, stall, pin_pd, cfg_pd, in_ready, frame_valid, fec_select;
    logic test_active, lane_ready;
    logic [5:0] mode, lane_enable, ovr;
    logic [1:0] shm;
    logic [3:0] ctl, tsel;
    logic [2:0] lane_octets;
    logic [7:0][15:0] smp;
    logic [5:0][31:0] lanes;
    logic [191:0] got;
    int miscompares, checks_done, cycles, n, cnt;
    logic [5:0] modes[8] = '{MODE_S12_6L, MODE_D12_6L, MODE_S8_4L, MODE_D8_4L, MODE_D15_4L,
        MODE_S15_2L, MODE_D15_2L, MODE_D15_2L16};
    logic [5:0] ens[8] = '{EN_6L, EN_6L, EN_4L, EN_4L, EN_4L, EN_2L, EN_2L, EN_2L};
    logic [2:0] octs[8] = '{OCT_2, OCT_2, OCT_1, OCT_1, OCT_2, OCT_2, OCT_4, OCT_4};

    // ==========================================================
    // Clock, design and receiver
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    slsm_top u_dut (.clk, .reset, .ce(1'b1), .lane_format_select(mode),
        .sync_header_mode(shm), .route_bind_a(ctl[0]), .route_bind_b(ctl[1]),
        .chan_a_powerdown(ctl[2]), .chan_b_powerdown(ctl[3]), .full_powerdown_pin(pin_pd),
        .cfg_mode_powerdown(cfg_pd), .serializer_test_select(tsel), .in_valid,
        .in_samples(smp), .overrange_first(ovr[0]), .overrange_second(ovr[1]),
        .overrange_chan_a_first(ovr[2]), .overrange_chan_a_second(ovr[3]),
        .overrange_chan_b_first(ovr[4]), .overrange_chan_b_second(ovr[5]),
        .lane_ready, .in_ready, .lane_a0(lanes[0]), .lane_a1(lanes[1]),
        .lane_a2(lanes[2]), .lane_b0(lanes[3]), .lane_b1(lanes[4]), .lane_b2(lanes[5]),
        .lane_enable, .lane_octets, .frame_valid, .fec_select, .test_active);
    slsm_rx_model u_rx (.clk, .stall, .frame_valid, .lanes, .lane_ready, .got);

    // ==========================================================
    // Expected lanes from the mode rules
    function automatic logic [191:0] exp_frame(input logic [5:0] m, input logic [3:0] c);
        logic [5:0][31:0] l, t;
        logic [47:0] g, h;
        l = '0;
        for (int k = 0; k < 4; k++) begin
            g[47-12*k -: 12] = smp[m == MODE_D12_6L ? k : 2*k][11:0];
            h[47-12*k -: 12] = smp[m == MODE_D12_6L ? k+4 : 2*k+1][11:0];
        end
        case (m)
            MODE_S12_6L, MODE_D12_6L: begin
                l = {h[15:0], 16'h0, h[31:16], 16'h0, h[47:32], 16'h0,
                    g[15:0], 16'h0, g[31:16], 16'h0, g[47:32], 16'h0};
            end
            MODE_S8_4L: l = {32'h0, smp[3][7:0], 24'h0, smp[1][7:0], 24'h0,
                32'h0, smp[2][7:0], 24'h0, smp[0][7:0], 24'h0};
            MODE_D8_4L: l = {32'h0, smp[3][7:0], 24'h0, smp[2][7:0], 24'h0,
                32'h0, smp[1][7:0], 24'h0, smp[0][7:0], 24'h0};
            MODE_D15_4L: l = {32'h0, smp[3][14:0], ovr[5], 16'h0, smp[2][14:0], ovr[4], 16'h0,
                32'h0, smp[1][14:0], ovr[3], 16'h0, smp[0][14:0], ovr[2], 16'h0};
            MODE_S15_2L: l = {64'h0, smp[1][14:0], ovr[1], 16'h0, 64'h0, smp[0][14:0], ovr[0],
                16'h0};
            MODE_D15_2L, MODE_D15_2L16: l = {64'h0, smp[2][14:0], ovr[4], smp[3][14:0], ovr[5],
                64'h0, smp[0][14:0], ovr[2], smp[1][14:0], ovr[3]};
            default: ;
        endcase
        if (m != MODE_S12_6L && m != MODE_S8_4L && m != MODE_S15_2L) begin
            if (c[2]) l[2:0] = '0;
            if (c[3]) l[5:3] = '0;
            t = l;
            if (c[0]) l[5:3] = t[2:0];
            if (c[1]) l[2:0] = t[5:3];
        end
        return l;
    endfunction

    // ==========================================================
    // Access tasks
    task automatic check(input logic [191:0] g, input logic [191:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Offer one word once ready
    task automatic send();
        int k;
        k = 0;
        while (in_ready !== 1'b1 && k < 50) begin
            tick(1);
            k++;
        end
        in_valid = 1'b1;
        tick(1);
        in_valid = 1'b0;
    endtask
    // One word to the receiver
    task automatic frame();
        int k;
        n = u_rx.seen.size();
        k = 0;
        send();
        while (u_rx.seen.size() == n && k < 30) begin
            tick(1);
            k++;
        end
        tick(1);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        {reset, in_valid, stall, pin_pd, cfg_pd, shm, ctl, tsel, cycles} = '0;
        reset = 1'b1;
        mode = MODE_S12_6L;
        ovr = 6'h25;
        for (int k = 0; k < 8; k++) smp[k] = 16'h8a5c + 16'h1357 * k;
        tick(5);
        reset = 1'b0;
        tick(1);
        check(in_ready, 1'b1);
        for (int i = 0; i < 8; i++) begin
            mode = modes[i];
            tick(2);
            frame();
            check(got, exp_frame(mode, 4'h0));
            check({lane_enable, lane_octets}, {ens[i], octs[i]});
        end
        // Binding and channel power-down
        for (int i = 0; i < 4; i++) begin
            mode = MODE_D15_4L;
            ctl = 4'h1 << i;
            tick(2);
            frame();
            check(got, exp_frame(mode, ctl));
        end
        mode = MODE_S8_4L;
        ctl = 4'h1;
        tick(2);
        frame();
        check(got, exp_frame(mode, 4'h0));
        ctl = 4'h0;
        // Unknown code drops the word
        mode = 6'h24;
        tick(2);
        n = u_rx.seen.size();
        send();
        tick(6);
        check({u_rx.seen.size() == n, lane_octets, lane_enable}, {1'b1, OCT_0, EN_NONE});
        for (int v = 0; v < 4; v++) begin
            shm = v[1:0];
            tick(2);
            check(fec_select, v == 1);
        end
        // Both power-down sources; no foreground calibration
        mode = MODE_D8_4L;
        for (int i = 0; i < 2; i++) begin
            {cfg_pd, pin_pd} = 2'h1 << i;
            tick(6);
            check({lane_enable, frame_valid}, {EN_NONE, 1'b0});
            n = u_rx.seen.size();
            send();
            {cfg_pd, pin_pd} = 2'h0;
            tick(8);
            check(u_rx.seen.size(), n);
            check(lane_enable, EN_4L);
        end
        // Test select with link idle
        mode = MODE_S15_2L;
        tsel = 4'h3;
        tick(3);
        check({test_active, lane_enable, frame_valid}, {1'b1, EN_2L, 1'b0});
        tsel = 4'h0;
        tick(3);
        check(test_active, 1'b0);
        // Fill stalled, drain in order
        mode = MODE_D8_4L;
        tick(2);
        u_rx.seen.delete();
        stall = 1'b1;
        cnt = 0;
        smp[0] = 16'h0;
        in_valid = 1'b1;
        repeat (40) begin
            if (in_ready === 1'b1) cnt++;
            @(posedge clk);
            #1 smp[0] = cnt[15:0];
        end
        in_valid = 1'b0;
        check(cnt, FIFO_DEPTH + 2);
        stall = 1'b0;
        tick(60);
        check(u_rx.seen.size(), cnt);
        for (int i = 0; i < u_rx.seen.size(); i++) check(u_rx.seen[i], i[7:0]);
        print_verdict();
    end
endmodule // slsm_top_bench

bind slsm_top slsm_props u_props (.clk, .reset, .ce, .lane_ready, .sync_header_mode,
    .cfg_mode_powerdown, .full_powerdown_pin, .serializer_test_select, .frame_valid,
    .lane_a0, .lane_b0, .lane_enable, .lane_octets, .fec_select, .test_active);

`default_nettype wire
